// *** core/isc_defs.svh ***
// Purpose: constants for the idle standby controller
// Assumes: 32-bit register port, word index addressing
// Notes: offsets are register indices
`ifndef ISC_DEFS_SVH
`define ISC_DEFS_SVH
`define ISC_ADR_MODE     4'h0
`define ISC_ADR_CTRL     4'h1
`define ISC_ADR_STABILISE_TIME_SELECT     4'h2
`define ISC_ADR_STAT     4'h3
`define ISC_ADR_CLKEN    4'h4
`define ISC_ADR_WAKE     4'h5
`define ISC_MODE_LIGHT   2'h0
`define ISC_MODE_DEEP    2'h2
`define ISC_B_TRIG       0
`define ISC_B_MASKABLE_IRQ_MASK       1
`define ISC_B_NMI_A_MASK      2
`define ISC_B_NMI_B_MASK      3
`define ISC_B_NF3        4
`define ISC_STABILISE_TIME_SELECT_RST     3'h4
`define ISC_STABILISE_TIME_SELECT_BASE    13
`define ISC_PLL_LOCK_US  20
`define ISC_CLK_MHZ      10
`endif

// *** core/isc_pkg.sv ***
// Purpose: types for the idle standby controller
// Assumes: nothing
// Notes: one-hot state codes
package isc_pkg;
  typedef enum logic [3:0] {
    ISC_NORMAL = 4'h1,
    ISC_LIGHT  = 4'h2,
    ISC_DEEP   = 4'h4,
    ISC_SETUP  = 4'h8
  } isc_state_t;
  typedef enum logic [1:0] {
    ISC_RESUME_NONE   = 2'h0,
    ISC_RESUME_NEXT   = 2'h1,
    ISC_RESUME_BRANCH = 2'h2
  } isc_resume_t;
endpackage

// *** core/isc_standby_ctrl.sv ***
// Purpose: light and deep idle control with clock gating and setup timer
// Assumes: registers over plain strobe port, data one cycle after read
// Notes: reset input release behaves as system reset
// Notes on behaviour
// - light idle leaves on nmi, unmasked external, unmasked peripheral irq, or reset
// - requests masked by control mask bits never wake
// - pin three cannot wake while its noise filter is on
// - release from light idle returns to normal mode
// - valid requests wake regardless of priority level
// - lower priority request in handler wakes but stays pending
// - higher priority request in handler wakes and is acknowledged only when enabled; nmi request always is
// - nmi branches; maskable branches only when enabled and of higher priority, else next instruction
// - reset release equals ordinary system reset
// - light idle retains state; detector and power-on-clear stay on
// - timer runs on subclock in light idle only with input select set
// - deep idle keeps main oscillator, gates cpu, pll, flash, peripherals
// - deep idle retains ram; subclock or external clocked units run
// - after deep idle, pll and flash setup enforced before resuming
// - deep idle entered with mode bits 10 and trigger write in normal
// - deep idle keeps oscillators, stops pll and cpu, holds ports
// - deep idle stops general timers; interval timer only on slow sources
// - deep idle watch timer runs on third prescaler only without subclock; watchdog runs
// - deep idle first async channel only on external clock, others stop
// - deep idle stops converter, two-wire, can; controller can still wake
// - deep idle wake counts programmed stabilisation until overflow
`timescale 1ns/1ps
`default_nettype none
`include "isc_defs.svh"
module isc_standby_ctrl #(
  parameter int NEXT = 8,
  parameter int PW   = 3,
  parameter int NTMR = 5,
  parameter int CW   = 24
) (
  input  wire logic                core_clk,
  input  wire logic                reset,
  input  wire logic [3:0]          reg_addr,
  input  wire logic [31:0]         reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic [31:0]              reg_rdata,
  input  wire logic                nmi_pin,
  input  wire logic                watchdog_irq,
  input  wire logic [NEXT-1:0]     ext_irq,
  input  wire logic [NEXT-1:0]     ext_unmasked,
  input  wire logic                periph_irq,
  input  wire logic [PW-1:0]       req_level,
  input  wire logic [PW-1:0]       cur_level,
  input  wire logic                in_handler,
  input  wire logic                irq_enabled,
  input  wire logic                subclock_present,
  input  wire logic [NTMR-1:0]     timer_input_select,
  output logic                     cpu_clk_en,
  output logic                     pll_en,
  output logic                     flash_clk_en,
  output logic                     periph_clk_en,
  output logic                     main_osc_en,
  output logic                     aux_osc_en,
  output logic                     port_hold,
  output logic                     ram_retain,
  output logic                     lvd_en,
  output logic [NTMR-1:0]          timer_run,
  output logic                     interval_timer_slow_only,
  output logic                     watch_timer_prescaler_only,
  output logic                     watchdog_run,
  output logic                     async_ext_clock_only,
  output logic                     async_other_run,
  output logic                     serial_ext_clock_only,
  output logic                     adc_run,
  output logic                     two_wire_run,
  output logic                     can_run,
  output logic                     intc_clk_en,
  output logic                     irq_ack,
  output isc_pkg::isc_resume_t     resume_action,
  output logic                     resume_pulse
);
  import isc_pkg::*;
  initial begin
    // the longest setup span, 2^20 plus lock, needs 21 counter bits
    if (CW < 21 || NTMR < 1) $error("bad counter or timer width");
  end
  localparam logic [CW-1:0] PLL_CYC = CW'(`ISC_PLL_LOCK_US * `ISC_CLK_MHZ);

  isc_state_t      state_q;
  logic [1:0]      mode_q;
  logic [4:1]      ctrl_q;
  logic [2:0]      stabilise_time_select_q;
  logic [CW-1:0]   cnt_q;
  logic [CW-1:0]   setup_len;
  isc_resume_t     act_q;
  logic            ack_q;
  logic            pulse_q;
  logic            higher_q;
  logic            nmi_q;
  logic [31:0]     rdata_q;
  logic            trig_wr;
  isc_wake_if      wk ();

  // ==========================================================
  // wake qualification
  isc_wake_filter #(.NEXT(NEXT), .PW(PW)) u_filt (
    .nmi_pin      (nmi_pin),
    .nmi_wdt      (watchdog_irq),
    .ext_irq      (ext_irq),
    .ext_unmasked (ext_unmasked),
    .periph_irq   (periph_irq),
    .req_level    (req_level),
    .cur_level    (cur_level),
    .in_handler   (in_handler),
    .ctrl         ({ctrl_q, 1'b0}),
    .wk           (wk)
  );

  // ==========================================================
  // register port
  assign trig_wr = reg_wr && reg_addr == `ISC_ADR_CTRL && reg_wdata[`ISC_B_TRIG];

  // synchronous reset doubles as the reset release path
  always_ff @(posedge core_clk) begin
    if (reset) begin
      mode_q <= `ISC_MODE_LIGHT;
      ctrl_q <= '0;
      stabilise_time_select_q <= `ISC_STABILISE_TIME_SELECT_RST;
    end else if (reg_wr) begin
      unique case (reg_addr)
        `ISC_ADR_MODE: mode_q <= reg_wdata[1:0];
        `ISC_ADR_CTRL: ctrl_q <= reg_wdata[4:1];
        `ISC_ADR_STABILISE_TIME_SELECT: stabilise_time_select_q <= reg_wdata[2:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      rdata_q <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `ISC_ADR_MODE:  rdata_q <= {30'h0, mode_q};
        `ISC_ADR_CTRL:  rdata_q <= {27'h0, ctrl_q, 1'b0};
        `ISC_ADR_STABILISE_TIME_SELECT:  rdata_q <= {29'h0, stabilise_time_select_q};
        `ISC_ADR_STAT:  rdata_q <= {28'h0, state_q};
        `ISC_ADR_CLKEN: rdata_q <= {28'h0, cpu_clk_en, pll_en, flash_clk_en, periph_clk_en};
        `ISC_ADR_WAKE:  rdata_q <= {29'h0, nmi_q, act_q};
        default:        rdata_q <= '0;
      endcase
    end else begin
      rdata_q <= '0;
    end
  end
  assign reg_rdata = rdata_q;

  // ==========================================================
  // setup interval: 2^(base+stabilise_time_select) cycles plus pll lock
  always_comb begin
    setup_len = (CW'(1) << (`ISC_STABILISE_TIME_SELECT_BASE + stabilise_time_select_q)) + PLL_CYC;
  end

  // ==========================================================
  // mode sequencer
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_q <= ISC_NORMAL;
      cnt_q   <= '0;
    end else begin
      unique case (state_q)
        ISC_NORMAL: begin
          // trigger in normal mode selects the idle depth
          if (trig_wr) begin
            state_q <= (mode_q == `ISC_MODE_DEEP) ? ISC_DEEP : ISC_LIGHT;
          end
        end
        ISC_LIGHT: begin
          if (wk.wake) begin
            state_q <= ISC_NORMAL;
          end
        end
        ISC_DEEP: begin
          // controller is unclocked yet its wake path stays live
          if (wk.wake) begin
            state_q <= ISC_SETUP;
            cnt_q   <= '0;
          end
        end
        ISC_SETUP: begin
          // resume once the counter reaches setup_len minus one
          if (cnt_q >= setup_len - CW'(1)) begin
            state_q <= ISC_NORMAL;
          end else begin
            cnt_q <= cnt_q + CW'(1);
          end
        end
      endcase
    end
  end

  // ==========================================================
  // wake outcome, latched at the wake edge
  always_ff @(posedge core_clk) begin
    if (reset) begin
      higher_q <= 1'b0;
      nmi_q    <= 1'b0;
    end else if ((state_q == ISC_LIGHT || state_q == ISC_DEEP) && wk.wake) begin
      higher_q <= wk.higher;
      nmi_q    <= wk.nmi_hit;
    end
  end

  logic resume_now;
  logic sel_nmi;
  logic sel_hi;
  assign resume_now = (state_q == ISC_LIGHT && wk.wake) ||
                      (state_q == ISC_SETUP && cnt_q >= setup_len - CW'(1));
  // deep wake resumes long after the sources may have dropped, so use the latch
  assign sel_nmi = (state_q == ISC_LIGHT) ? wk.nmi_hit : nmi_q;
  assign sel_hi  = (state_q == ISC_LIGHT) ? wk.higher : higher_q;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      act_q   <= ISC_RESUME_NONE;
      ack_q   <= 1'b0;
      pulse_q <= 1'b0;
    end else begin
      pulse_q <= resume_now;
      ack_q   <= 1'b0;
      if (resume_now) begin
        // lower priority stays pending, no acknowledge
        ack_q <= sel_hi & (sel_nmi | irq_enabled);
        // nmi branches, maskable depends on enable and priority
        if (sel_nmi || (irq_enabled && sel_hi)) begin
          act_q <= ISC_RESUME_BRANCH;
        end else begin
          act_q <= ISC_RESUME_NEXT;
        end
      end
    end
  end
  assign irq_ack       = ack_q;
  assign resume_action = act_q;
  assign resume_pulse  = pulse_q;

  // ==========================================================
  // clock and function gating
  logic lt;
  logic dp;
  assign lt = state_q == ISC_LIGHT;
  assign dp = state_q == ISC_DEEP;

  // cpu stops in both idles; pll, flash, peripherals only in deep
  assign cpu_clk_en    = state_q == ISC_NORMAL;
  assign pll_en        = ~dp;
  assign flash_clk_en  = ~dp;
  assign periph_clk_en = ~dp;
  assign main_osc_en   = 1'b1;
  assign aux_osc_en    = 1'b1;
  assign port_hold     = lt | dp;
  // state and ram are never cleared by idle
  assign ram_retain    = 1'b1;
  assign lvd_en        = 1'b1;
  // general timers: select bit in light idle, stopped in deep
  assign timer_run     = dp ? '0 : (lt ? timer_input_select : {NTMR{1'b1}});
  assign interval_timer_slow_only   = dp;
  // without subclock only the prescaler source survives
  assign watch_timer_prescaler_only = dp & ~subclock_present;
  assign watchdog_run  = 1'b1;
  assign async_ext_clock_only  = dp;
  assign async_other_run       = ~dp;
  assign serial_ext_clock_only = dp;
  // converter stops in both idles; software still idles it first to save power
  assign adc_run       = ~dp & ~lt;
  assign two_wire_run  = ~dp & ~lt;
  assign can_run       = ~dp & ~lt;
  assign intc_clk_en   = state_q == ISC_NORMAL || state_q == ISC_SETUP;
endmodule
`default_nettype wire

// *** core/isc_wake_filter.sv ***
// Purpose: qualify wake sources against masks and priority
// Assumes: priority levels smaller number = higher priority
// Notes: combinational
`timescale 1ns/1ps
`default_nettype none
`include "isc_defs.svh"
module isc_wake_filter #(
  parameter int NEXT = 8,
  parameter int PW   = 3
) (
  input  wire logic            nmi_pin,
  input  wire logic            nmi_wdt,
  input  wire logic [NEXT-1:0] ext_irq,
  input  wire logic [NEXT-1:0] ext_unmasked,
  input  wire logic            periph_irq,
  input  wire logic [PW-1:0]   req_level,
  input  wire logic [PW-1:0]   cur_level,
  input  wire logic            in_handler,
  input  wire logic [4:0]      ctrl,
  isc_wake_if.filt             wk
);
  logic [NEXT-1:0] ext_ok;
  initial begin
    if (NEXT < 4) $error("need at least four external pins");
  end
  // ==========================================================
  // qualification
  genvar i;
  generate
    for (i = 0; i < NEXT; i++) begin : g_ext
      if (i == 3) begin : g_p3
        // noise filter blocks this pin from waking
        assign ext_ok[i] = ext_irq[i] & ext_unmasked[i] & ~ctrl[`ISC_B_NF3];
      end else begin : g_px
        assign ext_ok[i] = ext_irq[i] & ext_unmasked[i];
      end
    end
  endgenerate
  // masked sources ignored
  assign wk.nmi_hit  = (nmi_pin & ~ctrl[`ISC_B_NMI_A_MASK]) | (nmi_wdt & ~ctrl[`ISC_B_NMI_B_MASK]);
  assign wk.mask_hit = ~ctrl[`ISC_B_MASKABLE_IRQ_MASK] & ((|ext_ok) | periph_irq);
  // wake regardless of priority
  assign wk.wake     = wk.nmi_hit | wk.mask_hit;
  // nmi always outranks a handler
  assign wk.higher   = wk.nmi_hit | ~in_handler | (req_level < cur_level);
endmodule
`default_nettype wire

// *** core/isc_wake_if.sv ***
// Purpose: wake decision bundle between top and wake filter
// Assumes: single clock
// Notes: plain levels
`timescale 1ns/1ps
`default_nettype none
interface isc_wake_if;
  logic wake;
  logic nmi_hit;
  logic mask_hit;
  logic higher;
  modport filt (output wake, output nmi_hit, output mask_hit, output higher);
  modport top  (input wake, input nmi_hit, input mask_hit, input higher);
endinterface
`default_nettype wire

// *** dv/isc_cpu_model.sv ***
// Purpose: cpu core and interrupt controller side of the wake requests
// Assumes: requests are levels held until served
// Notes: software never starts a conversion here, converter stays idle
`timescale 1ns/1ps
`default_nettype none
module isc_cpu_model #(
  parameter int NEXT = 8
) (
  input  wire logic            core_clk,
  input  wire logic            reset,
  input  wire logic            raise_nmi,
  input  wire logic [NEXT-1:0] raise_ext,
  input  wire logic            drop_all,
  input  wire logic            irq_ack,
  output logic                 nmi_pin,
  output logic [NEXT-1:0]      ext_irq
);
  // ==========================================
  // request holding
  // an unacknowledged request stays pending, so it must not vanish on wake
  always_ff @(posedge core_clk) begin
    if (reset || drop_all || irq_ack) begin
      nmi_pin <= 1'b0;
      ext_irq <= '0;
    end else begin
      nmi_pin <= nmi_pin | raise_nmi;
      ext_irq <= ext_irq | raise_ext;
    end
  end
endmodule
`default_nettype wire

// *** dv/isc_standby_chk.sv ***
// Purpose: port assertions for the standby controller
// Assumes: one clock, synchronous reset
// Notes: deep idle is seen at the ports as pll and cpu clocks both off
`timescale 1ns/1ps
`default_nettype none
module isc_standby_chk
  import isc_pkg::*;
#(
  parameter int PW   = 3,
  parameter int NTMR = 5
) (
  input wire logic                 core_clk,
  input wire logic                 reset,
  input wire logic                 nmi_pin,
  input wire logic                 watchdog_irq,
  input wire logic [PW-1:0]        req_level,
  input wire logic [PW-1:0]        cur_level,
  input wire logic                 in_handler,
  input wire logic                 irq_enabled,
  input wire logic [NTMR-1:0]      timer_input_select,
  input wire logic [31:0]          reg_rdata,
  input wire logic                 cpu_clk_en,
  input wire logic                 pll_en,
  input wire logic                 flash_clk_en,
  input wire logic                 periph_clk_en,
  input wire logic                 main_osc_en,
  input wire logic                 port_hold,
  input wire logic                 ram_retain,
  input wire logic                 lvd_en,
  input wire logic [NTMR-1:0]      timer_run,
  input wire logic                 watchdog_run,
  input wire logic                 adc_run,
  input wire logic                 two_wire_run,
  input wire logic                 can_run,
  input wire logic                 irq_ack,
  input wire isc_pkg::isc_resume_t resume_action,
  input wire logic                 resume_pulse
);
  // ==========================================
  // properties
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  wire logic deep = !pll_en && !cpu_clk_en;
  property p_rst;
    disable iff (1'b0) reset |=> cpu_clk_en && pll_en && !irq_ack && !resume_pulse
      && reg_rdata == 32'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_keep;
    ram_retain && lvd_en && watchdog_run;
  endproperty
  a_keep: assert property (p_keep) else $error("retention lost");
  property p_deep;
    deep |-> main_osc_en && !flash_clk_en && !periph_clk_en && port_hold;
  endproperty
  a_deep: assert property (p_deep) else $error("deep idle gating");
  property p_units;
    deep |-> timer_run == '0 && !adc_run && !two_wire_run && !can_run;
  endproperty
  a_units: assert property (p_units) else $error("unit runs in deep");
  property p_tmr;
    // light idle only: port hold tells it apart from the setup wait after deep idle
    !cpu_clk_en && pll_en && port_hold |-> (timer_run & ~timer_input_select) == '0;
  endproperty
  a_tmr: assert property (p_tmr) else $error("timer runs unselected");
  property p_act;
    resume_pulse |-> resume_action != ISC_RESUME_NONE;
  endproperty
  a_act: assert property (p_act) else $error("resume without action");
  property p_next;
    resume_pulse && !$past(nmi_pin || watchdog_irq || irq_enabled)
      |-> resume_action == ISC_RESUME_NEXT;
  endproperty
  a_next: assert property (p_next) else $error("disabled resume branched");
  property p_ack;
    irq_ack && !$past(nmi_pin || watchdog_irq)
      |-> $past(irq_enabled && (!in_handler || req_level < cur_level));
  endproperty
  a_ack: assert property (p_ack) else $error("lower request acked");
  property p_pulse;
    resume_pulse |=> !resume_pulse && cpu_clk_en;
  endproperty
  a_pulse: assert property (p_pulse) else $error("not back in normal");
endmodule
bind isc_standby_ctrl isc_standby_chk #(.PW(PW), .NTMR(NTMR)) isc_standby_chk_i (
  .core_clk, .reset, .nmi_pin, .watchdog_irq, .req_level, .cur_level, .in_handler,
  .irq_enabled, .timer_input_select, .reg_rdata, .cpu_clk_en, .pll_en, .flash_clk_en,
  .periph_clk_en, .main_osc_en, .port_hold, .ram_retain, .lvd_en, .timer_run,
  .watchdog_run, .adc_run, .two_wire_run, .can_run, .irq_ack, .resume_action,
  .resume_pulse);
`default_nettype wire

// *** dv/tb.sv ***
// Purpose: self-checking bench for the standby controller
// Assumes: nmi and external requests come from the cpu model
// Notes: stabilisation select 0 keeps the deep idle run short
`timescale 1ns/1ps
`default_nettype none
`include "isc_defs.svh"
module tb;
  import isc_pkg::*;
  // ==========================================
  // wiring
  logic        core_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic        watchdog_irq = 1'b0, periph_irq = 1'b0, in_handler = 1'b0;
  logic        irq_enabled = 1'b0, subclock_present = 1'b1, raise_nmi = 1'b0;
  logic        drop_all = 1'b0, nmi_pin, irq_ack, cpu_clk_en, pll_en;
  logic        main_osc_en, port_hold, resume_pulse, aux_osc_en, flash_clk_en, periph_clk_en;
  logic        it_slow, wt_pre, as_ext, as_oth, ser_ext, intc_en;
  logic [4:0]  timer_run;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic [7:0]  ext_irq, ext_unmasked = 8'hff, raise_ext = 8'h0;
  logic [2:0]  req_level = 3'h0, cur_level = 3'h0;
  logic [4:0]  timer_input_select = 5'h05;
  isc_resume_t resume_action;
  int          err_count, checked, acks, n, a0;
  isc_standby_ctrl #(.NEXT(8), .PW(3), .NTMR(5), .CW(24)) isc_standby_ctrl_i (
    .core_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .nmi_pin, .watchdog_irq, .ext_irq, .ext_unmasked, .periph_irq, .req_level,
    .cur_level, .in_handler, .irq_enabled, .subclock_present, .timer_input_select,
    .cpu_clk_en, .pll_en, .flash_clk_en, .periph_clk_en, .main_osc_en,
    .aux_osc_en, .port_hold, .ram_retain(), .lvd_en(), .timer_run,
    .interval_timer_slow_only(it_slow), .watch_timer_prescaler_only(wt_pre),
    .watchdog_run(), .async_ext_clock_only(as_ext), .async_other_run(as_oth),
    .serial_ext_clock_only(ser_ext), .adc_run(), .two_wire_run(), .can_run(),
    .intc_clk_en(intc_en), .irq_ack,
    .resume_action, .resume_pulse);
  isc_cpu_model #(.NEXT(8)) isc_cpu_model_i (.core_clk, .reset, .raise_nmi,
    .raise_ext, .drop_all, .irq_ack, .nmi_pin, .ext_irq);
  initial begin
    forever #50 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (irq_ack === 1'b1) acks++;
  // ==========================================
  // tasks
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic cbit(input string s, input logic e, input logic g);
    chk(s, {31'h0, e}, {31'h0, g});
  endtask
  task automatic cact(input isc_resume_t e);
    chk("action", {30'h0, e}, {30'h0, resume_action});
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdc(input string s, input logic [3:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(s, e, reg_rdata);
  endtask
  task automatic go(input logic [31:0] m, input logic [31:0] c);
    @(posedge core_clk);
    drop_all <= 1'b1;
    @(posedge core_clk);
    drop_all <= 1'b0;
    wr(`ISC_ADR_MODE, m);
    wr(`ISC_ADR_CTRL, c | 32'h1);
    repeat (5) @(posedge core_clk); // quiet five cycles after the entering store
  endtask
  task automatic raise(input logic nm, input logic [7:0] ex);
    @(posedge core_clk);
    raise_nmi <= nm;
    raise_ext <= ex;
    @(posedge core_clk);
    raise_nmi <= 1'b0;
    raise_ext <= 8'h0;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic wd(input logic v);
    @(posedge core_clk);
    watchdog_irq <= v;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic test_done;
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ==========================================
  // scenarios
  initial begin
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    rdc("mode", `ISC_ADR_MODE, 32'h0);
    rdc("stabilise_time_select", `ISC_ADR_STABILISE_TIME_SELECT, 32'h4);
    rdc("clken", `ISC_ADR_CLKEN, 32'hf);
    for (int m = 0; m < 4; m++) if (m != 2) begin
      go(32'(m), 32'h0);
      rdc("light", `ISC_ADR_STAT, 32'h2);
      cbit("cpu_en", 1'b0, cpu_clk_en);
      chk("tmr_lt", 32'h5, {27'h0, timer_run});
      raise(1'b1, 8'h0);
      rdc("woke", `ISC_ADR_STAT, 32'h1);
      cact(ISC_RESUME_BRANCH);
    end
    chk("acks", 32'h3, 32'(acks));
    go(32'h0, 32'h4);
    raise(1'b1, 8'h0);
    rdc("nmi_mask", `ISC_ADR_STAT, 32'h2);
    wd(1'b1);
    rdc("wdt_wake", `ISC_ADR_STAT, 32'h1);
    go(32'h0, 32'ha);
    raise(1'b0, 8'h01);
    rdc("int_mask", `ISC_ADR_STAT, 32'h2);
    raise(1'b1, 8'h0);
    rdc("nmi_wake", `ISC_ADR_STAT, 32'h1);
    wd(1'b0);
    go(32'h0, 32'h10);
    raise(1'b0, 8'h08);
    rdc("pin3", `ISC_ADR_STAT, 32'h2);
    raise(1'b0, 8'h01);
    rdc("ext_wake", `ISC_ADR_STAT, 32'h1);
    cact(ISC_RESUME_NEXT);
    @(posedge core_clk);
    irq_enabled <= 1'b1;
    in_handler <= 1'b1;
    cur_level <= 3'h2;
    req_level <= 3'h5;
    a0 = acks;
    go(32'h0, 32'h0);
    raise(1'b0, 8'h01);
    rdc("low_wake", `ISC_ADR_STAT, 32'h1);
    chk("no_ack", 32'(a0), 32'(acks));
    chk("pending", 32'h1, {24'h0, ext_irq});
    cact(ISC_RESUME_NEXT);
    @(posedge core_clk);
    req_level <= 3'h1;
    go(32'h0, 32'h0);
    raise(1'b0, 8'h01);
    chk("hi_ack", 32'(a0 + 1), 32'(acks));
    cact(ISC_RESUME_BRANCH);
    irq_enabled <= 1'b0;
    in_handler <= 1'b0;
    wr(`ISC_ADR_STABILISE_TIME_SELECT, 32'h0);
    go(32'h2, 32'h0);
    rdc("deep", `ISC_ADR_STAT, 32'h4);
    cbit("pll", 1'b0, pll_en);
    cbit("osc", 1'b1, main_osc_en);
    cbit("hold", 1'b1, port_hold);
    cbit("flash", 1'b0, flash_clk_en);
    cbit("periph", 1'b0, periph_clk_en);
    cbit("aux_osc", 1'b1, aux_osc_en);
    chk("tmr_dp", 32'h0, {27'h0, timer_run});
    cbit("it_slow", 1'b1, it_slow);
    cbit("wt_sub", 1'b0, wt_pre);
    cbit("as_ext", 1'b1, as_ext);
    cbit("as_oth", 1'b0, as_oth);
    cbit("ser_ext", 1'b1, ser_ext);
    cbit("intc", 1'b0, intc_en);
    @(posedge core_clk);
    subclock_present <= 1'b0;
    @(posedge core_clk);
    #1;
    cbit("wt_pre", 1'b1, wt_pre);
    @(posedge core_clk);
    subclock_present <= 1'b1;
    raise(1'b0, 8'h01);
    rdc("setup", `ISC_ADR_STAT, 32'h8);
    n = 0;
    while (resume_pulse !== 1'b1 && n < 9000) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    // wake edge lies a few cycles before the count starts
    cbit("setup_len", 1'b1, n >= 8385 && n <= 8395);
    rdc("resumed", `ISC_ADR_STAT, 32'h1);
    cact(ISC_RESUME_NEXT);
    go(32'h0, 32'h0);
    @(posedge core_clk);
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    rdc("rst_stat", `ISC_ADR_STAT, 32'h1);
    rdc("rst_stabilise_time_select", `ISC_ADR_STABILISE_TIME_SELECT, 32'h4);
    test_done;
  end
endmodule
`default_nettype wire
